// [verilog/mfsp_pkg.sv]
// Package with frame field constants and timing for the management serial port.
package mfsp_pkg;
    localparam int          MFSP_ADDR_W       = 5;
    localparam int          MFSP_DATA_W       = 16;
    localparam int          MFSP_PRE_LEN      = 32;
    localparam logic [1:0]  MFSP_START_CODE   = 2'h1;
    localparam logic [1:0]  MFSP_OP_READ      = 2'h2;
    localparam logic [1:0]  MFSP_OP_WRITE     = 2'h1;
    localparam logic [1:0]  MFSP_TA_WRITE     = 2'h2;
    localparam logic [4:0]  MFSP_PORT_ADDR_RST = 5'h00;
    localparam int          MFSP_CLK_PERIOD_PS = 5000;
    localparam int          MFSP_DRIVE_MAX_NS  = 300;
    localparam int          MFSP_DRIVE_MAX_CYC = (MFSP_DRIVE_MAX_NS * 1000) / MFSP_CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        MFSP_ST_PRE   = 3'h0,
        MFSP_ST_START = 3'h1,
        MFSP_ST_OP    = 3'h3,
        MFSP_ST_ADDR  = 3'h2,
        MFSP_ST_TA    = 3'h6,
        MFSP_ST_DATA  = 3'h7,
        MFSP_ST_IDLE  = 3'h5
    } mfsp_state_type;
endpackage

// [verilog/mfsp_port.sv]
// Device end of the management serial port: frame decode, register access, read drive.
// Summary of operation
// - Frames carry preamble, start, opcode, port address, register address, turnaround, data, idle.
// - Read uses start 01, opcode 10; device drives zero in second turnaround bit.
// - Device samples manager bits on the rising management clock edge.
// - Device changes or releases its driven data only after a rising clock edge.
// - After the last read data bit the device releases the line for idle.
`timescale 1ns/1ps
module mfsp_port
    import mfsp_pkg::*;
#(
    parameter int PRE_LEN = MFSP_PRE_LEN
) (
    input  wire logic                         mclk_i,        // System clock, 200 MHz.
    input  wire logic                         arst_n_i,      // Asynchronous reset, active low.
    input  wire logic                         mgmt_clk_i,    // Management clock from the manager.
    input  wire logic                         mgmt_data_i,   // Data line level as seen at the pin.
    output logic                              mgmt_data_o,   // Data line value when driven.
    output logic                              mgmt_data_oe_o, // High while the device drives data.
    input  wire logic [mfsp_pkg::MFSP_ADDR_W-1:0] port_address_i, // Own configured port address.
    output logic                              reg_wr_o,      // One-cycle register write strobe.
    output logic                              reg_rd_o,      // One-cycle register read strobe.
    output logic [mfsp_pkg::MFSP_ADDR_W-1:0]  reg_addr_o,    // Register address of the access.
    output logic [mfsp_pkg::MFSP_DATA_W-1:0]  reg_wdata_o,   // Write data of the access.
    input  wire logic [mfsp_pkg::MFSP_DATA_W-1:0] reg_rdata_i // Read data, valid cycle after reg_rd_o.
);
    import mfsp_pkg::*;

    // Two-stage synchronisers; stage one is read only by stage two.
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic       clk_prev;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_sync <= 2'h0;
            dat_sync <= 2'h3;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], mgmt_clk_i};
            dat_sync <= {dat_sync[0], mgmt_data_i};
            clk_prev <= clk_sync[1];
        end
    end

    wire rise = clk_sync[1] & ~clk_prev;
    wire bit_in = dat_sync[1];

    mfsp_state_type         state;
    mfsp_state_type         next_state;
    logic [5:0]             cnt;
    logic [5:0]             next_cnt;
    logic [15:0]            shreg;
    logic                   is_read;
    logic                   match;
    logic [MFSP_ADDR_W-1:0] paddr;
    logic [MFSP_DATA_W-1:0] rd_shift;
    logic                   rd_load;

    // Counting ones in the preamble; a zero before PRE_LEN ones restarts it, a zero after them is the first start bit.
    wire pre_done   = (cnt >= 6'(PRE_LEN));
    wire last_field = (cnt == 6'h0);
    wire addr_done  = (cnt == 6'h0);
    wire own_port   = (paddr == port_address_i);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            MFSP_ST_PRE: begin
                if (bit_in) begin
                    next_cnt = pre_done ? cnt : cnt + 6'h1;
                end else if (pre_done) begin
                    next_state = MFSP_ST_START;
                end else begin
                    next_cnt = 6'h0;
                end
            end
            MFSP_ST_START: begin
                // Second start bit must be one, forming 01.
                next_state = bit_in ? MFSP_ST_OP : MFSP_ST_PRE;
                next_cnt   = bit_in ? 6'h1 : 6'h0;
            end
            MFSP_ST_OP: begin
                next_cnt = cnt - 6'h1;
                if (last_field) begin
                    next_state = MFSP_ST_ADDR;
                    next_cnt   = 6'h9;
                end
            end
            MFSP_ST_ADDR: begin
                next_cnt = cnt - 6'h1;
                if (addr_done) begin
                    next_state = MFSP_ST_TA;
                    next_cnt   = 6'h1;
                end
            end
            MFSP_ST_TA: begin
                next_cnt = cnt - 6'h1;
                if (last_field) begin
                    next_state = MFSP_ST_DATA;
                    next_cnt   = 6'(MFSP_DATA_W - 1);
                end
            end
            MFSP_ST_DATA: begin
                next_cnt = cnt - 6'h1;
                if (last_field) begin
                    next_state = MFSP_ST_IDLE;
                    next_cnt   = 6'h0;
                end
            end
            MFSP_ST_IDLE: begin
                next_state = MFSP_ST_PRE;
                next_cnt   = bit_in ? 6'h1 : 6'h0;
            end
            default: begin
                next_state = MFSP_ST_PRE;
                next_cnt   = 6'h0;
            end
        endcase
    end

    // Opcode and address words are each used twice, so they are formed once here.
    wire [1:0]             op_word   = {shreg[0], bit_in};
    wire [MFSP_ADDR_W-1:0] addr_word = {shreg[3:0], bit_in};

    // Only the read and write codes start an access; anything else resyncs.
    function automatic logic op_known(input logic [1:0] code);
        return (code == MFSP_OP_READ) || (code == MFSP_OP_WRITE);
    endfunction

    wire op_ok     = (state == MFSP_ST_OP) && last_field && op_known(op_word);
    wire op_bad    = (state == MFSP_ST_OP) && last_field && !op_ok;
    wire addr_end  = (state == MFSP_ST_ADDR) && addr_done;
    wire ta_first  = (state == MFSP_ST_TA) && (cnt == 6'h1);
    wire data_end  = (state == MFSP_ST_DATA) && last_field;
    wire rd_active = match && is_read;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= MFSP_ST_PRE;
            cnt   <= 6'h0;
        end else if (rise) begin
            state <= op_bad ? MFSP_ST_PRE : next_state;
            cnt   <= op_bad ? 6'h0 : next_cnt;
        end
    end

    // Incoming bit shift register, MSB first.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shreg   <= 16'h0000;
            is_read <= 1'b0;
            match   <= 1'b0;
            paddr   <= MFSP_PORT_ADDR_RST;
        end else if (rise) begin
            shreg <= {shreg[14:0], bit_in};
            if (op_ok) begin
                is_read <= (op_word == MFSP_OP_READ);
            end
            if ((state == MFSP_ST_ADDR) && (cnt == 6'h5)) begin
                paddr <= addr_word;
            end
            if (addr_end) begin
                match <= own_port;
            end
            if (state == MFSP_ST_PRE) begin
                match <= 1'b0;
            end
        end
    end

    // Register access strobes; read data fetched at the end of the address field.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_wr_o    <= 1'b0;
            reg_rd_o    <= 1'b0;
            reg_addr_o  <= 5'h00;
            reg_wdata_o <= 16'h0000;
            rd_load     <= 1'b0;
        end else begin
            reg_rd_o <= rise && addr_end && is_read && own_port;
            rd_load  <= reg_rd_o;
            reg_wr_o <= rise && data_end && match && !is_read;
            if (rise && addr_end) begin
                reg_addr_o <= addr_word;
            end
            if (rise && data_end) begin
                reg_wdata_o <= {shreg[14:0], bit_in};
            end
        end
    end

    // Output drive changes only on a detected rising edge, so the line follows the
    // manager's clock; the 3-cycle detection lag is well inside the allowed delay.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_shift       <= 16'h0000;
            mgmt_data_o    <= 1'b0;
            mgmt_data_oe_o <= 1'b0;
        end else begin
            if (rd_load) begin
                rd_shift <= reg_rdata_i;
            end
            if (rise) begin
                if (ta_first && rd_active) begin
                    mgmt_data_o    <= 1'b0;
                    mgmt_data_oe_o <= 1'b1;
                end else if ((state == MFSP_ST_TA) && rd_active) begin
                    mgmt_data_o    <= rd_shift[15];
                    rd_shift       <= {rd_shift[14:0], 1'b0};
                end else if ((state == MFSP_ST_DATA) && rd_active && !last_field) begin
                    mgmt_data_o    <= rd_shift[15];
                    rd_shift       <= {rd_shift[14:0], 1'b0};
                end else begin
                    mgmt_data_o    <= 1'b0;
                    mgmt_data_oe_o <= 1'b0;
                end
            end
        end
    end
endmodule

// [testbench/mfsp_port_sva.sv]
// Checker for the line drive and register strobes of the management serial port.
`timescale 1ns/1ps
module mfsp_port_sva (
    input wire logic mclk_i,         // System clock.
    input wire logic arst_n_i,       // Reset, active low.
    input wire logic mgmt_clk_i,     // Management clock.
    input wire logic mgmt_data_o,    // Driven line value.
    input wire logic mgmt_data_oe_o, // Line drive enable.
    input wire logic reg_wr_o,       // Write strobe.
    input wire logic reg_rd_o        // Read strobe.
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    logic [5:0] rises;
    // Link clock rises while driving; a whole read drive spans the turnaround zero
    // and the sixteen data slots, so seventeen rises pass before the release.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            rises <= 6'h00;
        else if (!mgmt_data_oe_o)
            rises <= 6'h00;
        else if ($rose(mgmt_clk_i))
            rises <= rises + 6'h01;
    end
    sequence s_rd_req;
        reg_rd_o;
    endsequence
    sequence s_ta_drive;
        $rose(mgmt_data_oe_o) && !mgmt_data_o;
    endsequence
    a_oe_after_clk: assert property ($changed(mgmt_data_oe_o) |-> mgmt_clk_i && !$past(mgmt_clk_i, 7))
        else $error("drive enable moved away from a link clock rise");
    a_data_after_clk: assert property (($changed(mgmt_data_o) && mgmt_data_oe_o)
        |-> mgmt_clk_i && !$past(mgmt_clk_i, 7))
        else $error("driven value moved away from a link clock rise");
    a_read_drive: assert property (s_rd_req |-> ##[20:80] s_ta_drive)
        else $error("read not followed by turnaround drive");
    a_ta_zero: assert property ($rose(mgmt_data_oe_o) |-> !mgmt_data_o)
        else $error("turnaround drive is not zero");
    a_drive_len: assert property ($fell(mgmt_data_oe_o) |-> rises == 6'h11)
        else $error("line not released after sixteen data slots");
    a_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o)
        else $error("write strobe longer than one cycle");
    a_rd_pulse: assert property (reg_rd_o |=> !reg_rd_o)
        else $error("read strobe longer than one cycle");
    a_strobe_excl: assert property (!(reg_wr_o && reg_rd_o))
        else $error("read and write strobes together");
endmodule

// [testbench/mfsp_mgr.sv]
// Station manager model: makes the link clock and sends whole frames.
`timescale 1ns/1ps
module mfsp_mgr (
    output logic     mdc_o,   // Link clock, still between frames.
    output logic     md_o,    // Line value while driving.
    output logic     md_oe_o, // High while driving.
    input wire logic md_i     // Resolved line level.
);
    logic [15:0] sh;
    initial mdc_o = 1'b0;
    initial md_o = 1'b1;
    initial md_oe_o = 1'b0;
    // One 125 ns bit; data leads the sampling rise by 60 ns. The uneven halves keep
    // every link edge on a falling system clock edge, away from the design's sampling.
    task automatic bit_x(input logic oe, input logic v);
        mdc_o = 1'b0;
        md_oe_o = oe;
        md_o = v;
        #60;
        mdc_o = 1'b1;
        sh = {sh[14:0], md_i};
        #65;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q, output logic ta,
                         output logic idl);
        logic [45:0] hdr;
        logic        wr;
        hdr = {32'hffff_ffff, mfsp_pkg::MFSP_START_CODE, op, pa, ra};
        wr = (op == mfsp_pkg::MFSP_OP_WRITE);
        for (int i = 45; i >= 0; i--)
            bit_x(1'b1, hdr[i]);
        for (int i = 1; i >= 0; i--)
            bit_x(wr, mfsp_pkg::MFSP_TA_WRITE[i]);
        ta = sh[0];
        for (int i = 15; i >= 0; i--)
            bit_x(wr, wd[i]);
        q = sh;
        bit_x(1'b0, 1'b1);
        idl = sh[0];
    endtask
endmodule

// [testbench/mfsp_port_tb.sv]
// Testbench for the management serial port against a manager model and register file.
`timescale 1ns/1ps
module mfsp_port_tb;
    import mfsp_pkg::*;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        mdc, mo, moe, d_o, d_oe, wr, rd, ta, idl, hit;
    logic [4:0]  pa = 5'h0b;
    logic [4:0]  ra, a, r;
    logic [15:0] wd, rdat = 16'h0000, w, q, regs [32];
    logic [21:0] sq [$];
    logic [21:0] e;
    int          checks = 0, num_errors = 0, cyc = 0;
    wire         line = d_oe ? d_o : (moe ? mo : 1'b1); // Pull-up when released.
    always #2.5 mclk_i = ~mclk_i;
    mfsp_mgr u_mgr (.mdc_o(mdc), .md_o(mo), .md_oe_o(moe), .md_i(line));
    mfsp_port #(.PRE_LEN(32)) i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .mgmt_clk_i(mdc),
        .mgmt_data_i(line), .mgmt_data_o(d_o), .mgmt_data_oe_o(d_oe), .port_address_i(pa),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ra), .reg_wdata_o(wd), .reg_rdata_i(rdat));
    task automatic check(input logic [21:0] got, input logic [21:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Strobes are matched against the expected access queue; an extra one is a mismatch.
    always @(negedge mclk_i) begin
        cyc++;
        if (wr === 1'b1 || rd === 1'b1) begin
            e = (sq.size() > 0) ? sq.pop_front() : 22'h3fffff;
            check({wr, ra, wr ? wd : 16'h0000}, e);
        end
        if (rd === 1'b1)
            rdat <= regs[ra];
        if (cyc == 60000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        w = 16'($urandom(33537));
        for (int i = 0; i < 32; i++)
            regs[i] = 16'($urandom);
        repeat (6) @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        for (int n = 0; n < 12; n++) begin
            hit = (n % 3 != 2);
            a = hit ? pa : pa ^ 5'($urandom_range(1, 31));
            r = 5'($urandom);
            w = 16'($urandom);
            if (hit) begin
                sq.push_back({1'b1, r, w});
                sq.push_back({1'b0, r, 16'h0000});
                regs[r] = w;
            end
            u_mgr.frame(MFSP_OP_WRITE, a, r, w, q, ta, idl);
            u_mgr.frame(MFSP_OP_READ, a, r, 16'h0000, q, ta, idl);
            check({4'h0, ta, idl, q}, {4'h0, ~hit, 1'b1, hit ? regs[r] : 16'hffff});
            check({21'h0, d_oe}, 22'h0);
        end
        u_mgr.frame(2'h3, pa, r, 16'h0000, q, ta, idl);
        check({4'h0, ta, idl, q}, {4'h0, 1'b1, 1'b1, 16'hffff});
        check(22'(sq.size()), 22'h0);
        close_out();
    end
endmodule
bind mfsp_port mfsp_port_sva i_sva (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .mgmt_clk_i(mgmt_clk_i),
    .mgmt_data_o(mgmt_data_o), .mgmt_data_oe_o(mgmt_data_oe_o), .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o));
